// file: uart_msr_consts.svh
// register offsets, field positions and reset values of the modem status and enable bank
`ifndef UART_MSR_CONSTS_SVH
`define UART_MSR_CONSTS_SVH

// apb byte addresses, one aligned word each
`define OFF_IE_MASK 8'h04
`define OFF_IDENT 8'h08
`define OFF_MODEM_CTRL 8'h0c
`define OFF_PIN_CFG 8'h10
`define OFF_ENH_FEAT 8'h14
`define OFF_MODEM_STAT 8'h18
`define OFF_SCRATCH 8'h1c
`define OFF_PIN_LEVEL 8'h20
`define OFF_FLOW_EVT 8'h24

// interrupt enable mask fields
`define IE_RX_DATA 0
`define IE_TX_HOLD 1
`define IE_LINE_ERR 2
`define IE_MODEM 3
`define IE_SLEEP 4
`define IE_XOFF 5
`define IE_RTS 6
`define IE_CTS 7

// modem status fields
`define MS_DCTS 0
`define MS_DDSR 1
`define MS_TERI 2
`define MS_DCD 3
`define MS_CTS 4
`define MS_DSR 5
`define MS_RI 6
`define MS_CD 7

// modem control fields
`define MC_DTR 0
`define MC_RTS 1
`define MC_LOOP 4

// pin configuration and enhanced feature fields
`define PC_MODEM_SEL 1
`define EF_WR_EN 4

// general pins that double as modem inputs
`define GP_DSR 4
`define GP_CD 6
`define GP_RI 7

// flow event fields
`define FE_CTS_RISE 0
`define FE_RTS_RISE 1

// identification codes, bits 5:0 of the ident register
`define ID_LINE_ERR 6'h06
`define ID_RX_DATA 6'h04
`define ID_TX_HOLD 6'h02
`define ID_MODEM 6'h00
`define ID_XOFF 6'h10
`define ID_FLOW 6'h20
`define ID_NONE 6'h01

// reset values
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000

`endif

// file: uart_msr_pkg.sv
// types shared by the modem status and interrupt enable bank
package uart_msr_pkg;

  // apb request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // levels of the modem side pins, all active low except general pins raw
  typedef struct packed {
    logic [7:0] gpio;
    logic cts_n;
    logic rts_n;
  } modem_pins_t;

  // levels from the rest of the uart that may raise an interrupt
  typedef struct packed {
    logic rx_data_avail;
    logic rx_line_err;
    logic tx_below_thresh;
    logic xoff_rcvd;
  } uart_evt_t;

endpackage : uart_msr_pkg

// file: uart_msr_ier.sv
// modem status, scratch pad and interrupt enable register bank on apb
`timescale 1ns/1ps
`include "uart_msr_consts.svh"

module uart_msr_ier (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire uart_msr_pkg::apb_req_t APB_REQ_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire uart_msr_pkg::modem_pins_t PINS_I,
  input wire uart_msr_pkg::uart_evt_t EVT_I,
  output logic RTS_N_O,
  output logic DTR_N_O,
  output logic SLEEP_REQ_O,
  output logic IRQ_N_O
);
  import uart_msr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [7:0] interrupt_enable_mask_reg;
  logic [7:0] modem_control_reg;
  logic [7:0] pin_config_reg;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] scratch_pad_reg;
  logic [3:0] delta_reg;
  logic [1:0] flow_evt_reg;
  logic thr_pend_reg;
  logic [3:0] stat_prev_reg;
  logic rts_prev_reg;
  logic tx_below_prev_reg;
  logic [31:0] prdata_reg;
  logic [3:0] clr_delta_reg;
  logic [1:0] clr_flow_reg;
  logic clr_thr_reg;
  logic irq_n_reg;
  logic hit;
  logic wr_done;
  logic rd_setup;
  logic rd_done;
  logic [3:0] stat_now;
  logic [7:0] modem_line_status;
  logic [7:0] pin_level;
  logic [7:0] ident;
  logic pending;
  logic modem_sel;
  logic loop_on;

  // every access finishes in its first access cycle
  assign PREADY_O = 1'b1;
  assign wr_done = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite;
  assign rd_setup = APB_REQ_I.psel & ~APB_REQ_I.penable & ~APB_REQ_I.pwrite;
  assign rd_done = APB_REQ_I.psel & APB_REQ_I.penable & ~APB_REQ_I.pwrite;

  // address hit check, unmapped words answer with an error
  always_comb begin
    case (APB_REQ_I.paddr)
      `OFF_IE_MASK, `OFF_IDENT, `OFF_MODEM_CTRL, `OFF_PIN_CFG, `OFF_ENH_FEAT,
      `OFF_MODEM_STAT, `OFF_SCRATCH, `OFF_PIN_LEVEL, `OFF_FLOW_EVT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign PSLVERR_O = APB_REQ_I.psel & APB_REQ_I.penable & ~hit;

  ////////////////////////////////////////////////////////////////////////////////
  // modem input conditioning

  assign modem_sel = pin_config_reg[`PC_MODEM_SEL];
  assign loop_on = modem_control_reg[`MC_LOOP];

  // active high status, pins are inverted; loopback takes rts/dtr bits instead
  // status order: {cd, ri, dsr, cts}
  always_comb begin
    stat_now[3] = modem_sel & ~PINS_I.gpio[`GP_CD];
    stat_now[2] = modem_sel & ~PINS_I.gpio[`GP_RI];
    if (loop_on) begin
      stat_now[1] = modem_control_reg[`MC_DTR];
      stat_now[0] = modem_control_reg[`MC_RTS];
    end else begin
      stat_now[1] = modem_sel & ~PINS_I.gpio[`GP_DSR];
      stat_now[0] = ~PINS_I.cts_n;
    end
  end

  assign modem_line_status = {stat_now, delta_reg};

  // general pins used as modem inputs read zero here, software must use the status
  always_comb begin
    pin_level = PINS_I.gpio;
    if (modem_sel) begin
      pin_level[`GP_DSR] = 1'b0;
      pin_level[`GP_CD] = 1'b0;
      pin_level[`GP_RI] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt gating and identification

  // pending sources in priority order; the first hit names the ident code
  always_comb begin
    pending = 1'b1;
    ident = {2'b00, `ID_NONE};
    if (interrupt_enable_mask_reg[`IE_LINE_ERR] & EVT_I.rx_line_err) begin
      ident = {2'b00, `ID_LINE_ERR};
    end else if (interrupt_enable_mask_reg[`IE_RX_DATA] & EVT_I.rx_data_avail) begin
      ident = {2'b00, `ID_RX_DATA};
    end else if (interrupt_enable_mask_reg[`IE_TX_HOLD] & thr_pend_reg) begin
      ident = {2'b00, `ID_TX_HOLD};
    end else if (interrupt_enable_mask_reg[`IE_MODEM] & (|delta_reg)) begin
      ident = {2'b00, `ID_MODEM};
    end else if (interrupt_enable_mask_reg[`IE_XOFF] & EVT_I.xoff_rcvd) begin
      ident = {2'b00, `ID_XOFF};
    end else if ((interrupt_enable_mask_reg[`IE_CTS] & flow_evt_reg[`FE_CTS_RISE])
                 | (interrupt_enable_mask_reg[`IE_RTS] & flow_evt_reg[`FE_RTS_RISE])) begin
      ident = {2'b00, `ID_FLOW};
    end else begin
      pending = 1'b0;
    end
  end

  // interrupt pin, registered so it never glitches
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      irq_n_reg <= 1'b1;
    end else begin
      irq_n_reg <= ~pending;
    end
  end
  assign IRQ_N_O = irq_n_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // software writable registers

  // enable mask; upper nibble locked unless the feature write enable is set
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      interrupt_enable_mask_reg <= `RST_BYTE;
    end else if (wr_done && APB_REQ_I.paddr == `OFF_IE_MASK) begin
      interrupt_enable_mask_reg[3:0] <= APB_REQ_I.pwdata[3:0];
      if (enhanced_feature_reg[`EF_WR_EN]) begin
        interrupt_enable_mask_reg[7:4] <= APB_REQ_I.pwdata[7:4];
      end
    end
  end

  // control registers feeding loopback, pin mode and the write lock
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      modem_control_reg <= `RST_BYTE;
      pin_config_reg <= `RST_BYTE;
      enhanced_feature_reg <= `RST_BYTE;
    end else if (wr_done) begin
      if (APB_REQ_I.paddr == `OFF_MODEM_CTRL) begin
        modem_control_reg <= APB_REQ_I.pwdata[7:0];
      end
      if (APB_REQ_I.paddr == `OFF_PIN_CFG) begin
        pin_config_reg <= APB_REQ_I.pwdata[7:0];
      end
      if (APB_REQ_I.paddr == `OFF_ENH_FEAT) begin
        enhanced_feature_reg <= APB_REQ_I.pwdata[7:0];
      end
    end
  end

  // scratch byte touches nothing else
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      scratch_pad_reg <= `RST_BYTE;
    end else if (wr_done && APB_REQ_I.paddr == `OFF_SCRATCH) begin
      scratch_pad_reg <= APB_REQ_I.pwdata[7:0];
    end
  end

  // outputs driven from control and enable bits; rts and dtr pins are active low, sleep request is active high
  assign RTS_N_O = ~modem_control_reg[`MC_RTS];
  assign DTR_N_O = ~modem_control_reg[`MC_DTR];
  assign SLEEP_REQ_O = interrupt_enable_mask_reg[`IE_SLEEP];

  ////////////////////////////////////////////////////////////////////////////////
  // read path; data is captured in setup so read-clear only drops bits seen

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      prdata_reg <= `RST_WORD;
      clr_delta_reg <= 4'h0;
      clr_flow_reg <= 2'h0;
      clr_thr_reg <= 1'b0;
    end else if (rd_setup) begin
      clr_delta_reg <= 4'h0;
      clr_flow_reg <= 2'h0;
      clr_thr_reg <= 1'b0;
      case (APB_REQ_I.paddr)
        `OFF_IE_MASK: prdata_reg <= {24'h0, interrupt_enable_mask_reg};
        `OFF_IDENT: begin
          prdata_reg <= {24'h0, ident};
          clr_thr_reg <= (ident[5:0] == `ID_TX_HOLD);
        end
        `OFF_MODEM_CTRL: prdata_reg <= {24'h0, modem_control_reg};
        `OFF_PIN_CFG: prdata_reg <= {24'h0, pin_config_reg};
        `OFF_ENH_FEAT: prdata_reg <= {24'h0, enhanced_feature_reg};
        `OFF_MODEM_STAT: begin
          prdata_reg <= {24'h0, modem_line_status};
          clr_delta_reg <= delta_reg;
        end
        `OFF_SCRATCH: prdata_reg <= {24'h0, scratch_pad_reg};
        `OFF_PIN_LEVEL: prdata_reg <= {24'h0, pin_level};
        `OFF_FLOW_EVT: begin
          prdata_reg <= {30'h0, flow_evt_reg};
          clr_flow_reg <= flow_evt_reg;
        end
        default: prdata_reg <= `RST_WORD;
      endcase
    end
  end
  assign PRDATA_O = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // sticky change flags; a new event in the clearing cycle wins

  logic [3:0] delta_evt;
  logic [1:0] flow_evt;
  logic thr_evt;
  logic rts_now;

  assign rts_now = ~PINS_I.rts_n;
  // order {dcd, teri, ddsr, dcts}; teri only on pin low to high
  assign delta_evt = {stat_now[3] ^ stat_prev_reg[3],
                      stat_prev_reg[2] & ~stat_now[2],
                      stat_now[1] ^ stat_prev_reg[1],
                      stat_now[0] ^ stat_prev_reg[0]};
  // pin low to high means the active high status falls
  assign flow_evt = {rts_prev_reg & ~rts_now, stat_prev_reg[0] & ~stat_now[0]};
  // only a fresh fall below the threshold counts, not a re-enable
  assign thr_evt = EVT_I.tx_below_thresh & ~tx_below_prev_reg;

  // previous levels for edge detection
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      stat_prev_reg <= 4'h0;
      rts_prev_reg <= 1'b0;
      tx_below_prev_reg <= 1'b0;
    end else begin
      stat_prev_reg <= stat_now;
      rts_prev_reg <= rts_now;
      tx_below_prev_reg <= EVT_I.tx_below_thresh;
    end
  end

  // modem change flags, cleared by a completed status read
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      delta_reg <= 4'h0;
    end else if (rd_done && APB_REQ_I.paddr == `OFF_MODEM_STAT) begin
      delta_reg <= (delta_reg & ~clr_delta_reg) | delta_evt;
    end else begin
      delta_reg <= delta_reg | delta_evt;
    end
  end

  // flow change flags, cleared by a completed flow event read
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      flow_evt_reg <= 2'h0;
    end else if (rd_done && APB_REQ_I.paddr == `OFF_FLOW_EVT) begin
      flow_evt_reg <= (flow_evt_reg & ~clr_flow_reg) | flow_evt;
    end else begin
      flow_evt_reg <= flow_evt_reg | flow_evt;
    end
  end

  // transmit holding request; ends on ident read showing it or on refill
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      thr_pend_reg <= 1'b0;
    end else if (thr_evt) begin
      thr_pend_reg <= 1'b1;
    end else if (!EVT_I.tx_below_thresh) begin
      thr_pend_reg <= 1'b0;
    end else if (rd_done && APB_REQ_I.paddr == `OFF_IDENT && clr_thr_reg) begin
      thr_pend_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  property p_cd_status;
    modem_sel |-> modem_line_status[`MS_CD] == ~PINS_I.gpio[`GP_CD];
  endproperty
  a_cd_status: assert property (p_cd_status)
    else $error("cd status not inverted pin");

  property p_cts_status;
    !loop_on |-> modem_line_status[`MS_CTS] == ~PINS_I.cts_n;
  endproperty
  a_cts_status: assert property (p_cts_status)
    else $error("cts status not inverted pin");

  property p_dcts_set;
    !loop_on && $changed(PINS_I.cts_n) && !$past(RST_I) |=> delta_reg[`MS_DCTS];
  endproperty
  a_dcts_set: assert property (p_dcts_set)
    else $error("cts change flag missed");

  property p_teri_fall_only;
    modem_sel && $fell(PINS_I.gpio[`GP_RI]) && !delta_reg[`MS_TERI] && !rd_done
      |=> !delta_reg[`MS_TERI];
  endproperty
  a_teri_fall_only: assert property (p_teri_fall_only)
    else $error("ring flag set on wrong edge");

  property p_ie_lock;
    wr_done && APB_REQ_I.paddr == `OFF_IE_MASK && !enhanced_feature_reg[`EF_WR_EN]
      |=> interrupt_enable_mask_reg[7:4] == $past(interrupt_enable_mask_reg[7:4]);
  endproperty
  a_ie_lock: assert property (p_ie_lock)
    else $error("locked enable bits changed");

  property p_scratch;
    wr_done && APB_REQ_I.paddr == `OFF_SCRATCH |=> scratch_pad_reg == $past(APB_REQ_I.pwdata[7:0]);
  endproperty
  a_scratch: assert property (p_scratch)
    else $error("scratch byte lost");

  property p_irq_follow;
    pending |=> !IRQ_N_O;
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("irq not raised");

  property p_modem_irq;
    interrupt_enable_mask_reg[`IE_MODEM] && (|delta_reg) |=> !IRQ_N_O;
  endproperty
  a_modem_irq: assert property (p_modem_irq)
    else $error("modem irq not pending");

  property p_ident_bit0;
    ident[0] == !pending;
  endproperty
  a_ident_bit0: assert property (p_ident_bit0)
    else $error("ident bit 0 wrong");

  property p_thr_reenable;
    $rose(interrupt_enable_mask_reg[`IE_TX_HOLD]) && !thr_pend_reg && !thr_evt
      |-> !pending || ident[5:0] != `ID_TX_HOLD;
  endproperty
  a_thr_reenable: assert property (p_thr_reenable)
    else $error("re-enable raised transmit irq");

  property p_loop;
    loop_on |-> modem_line_status[`MS_CTS] == modem_control_reg[`MC_RTS]
      && modem_line_status[`MS_DSR] == modem_control_reg[`MC_DTR];
  endproperty
  a_loop: assert property (p_loop)
    else $error("loopback status wrong");

  property p_sleep;
    $changed(SLEEP_REQ_O) |-> $past(wr_done && APB_REQ_I.paddr == `OFF_IE_MASK);
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep request mismatch");

  c_modem_read_clear: cover property (
    rd_done && APB_REQ_I.paddr == `OFF_MODEM_STAT && (|clr_delta_reg));
  c_irq_raised: cover property ($fell(IRQ_N_O));
  c_locked_write: cover property (
    wr_done && APB_REQ_I.paddr == `OFF_IE_MASK && !enhanced_feature_reg[`EF_WR_EN]);
  c_flow_rise: cover property (|flow_evt);

endmodule : uart_msr_ier

// file: modem_side_model.sv
// far side of the modem lines: drives the active low inputs of the bank
`timescale 1ns/1ps

module modem_side_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] gpio_cmd_i,
  input wire logic cts_cmd_i,
  input wire logic rts_n_dev_i,
  output uart_msr_pkg::modem_pins_t pins_o
);
  import uart_msr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // lines change only after an edge, as a real modem would, never mid-cycle
  // during reset the lines sit at their pull-up level, all inactive (high)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_o <= '1;
    end else begin
      pins_o.gpio <= gpio_cmd_i; // bit4 dsr, bit6 cd, bit7 ri
      pins_o.cts_n <= cts_cmd_i;
      pins_o.rts_n <= rts_n_dev_i; // rts seen on the line one cycle late
    end
  end
endmodule : modem_side_model

// file: uart_msr_ier_tb.sv
// self-checking bench for the modem status and interrupt enable bank
`timescale 1ns/1ps
`include "uart_msr_consts.svh"

module uart_msr_ier_tb;
  import uart_msr_pkg::*;
  logic clk;
  logic rst;
  apb_req_t req;
  uart_evt_t evt;
  modem_pins_t pins;
  logic [7:0] gpio_cmd;
  logic cts_cmd;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rts_n;
  logic dtr_n;
  logic sleep_req;
  logic irq_n;
  logic [31:0] rdata;
  logic rerr;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [8:0] lv_tab [6] = '{9'h0ff, 9'h0bf, 9'h0af, 9'h02f, 9'h0af, 9'h0ff};
  logic [7:0] ex1 [6] = '{8'h11, 8'h98, 8'hb2, 8'hf0, 8'hb4, 8'h1a};
  logic [7:0] ex2 [6] = '{8'h10, 8'h90, 8'hb0, 8'hf0, 8'hb0, 8'h10};
  logic [3:0] ev_tab [3] = '{4'h8, 4'h4, 4'h1};
  logic [7:0] msk_tab [3] = '{8'h01, 8'h04, 8'h20};
  logic [7:0] id_tab [3] = '{8'h04, 8'h06, 8'h10};

  uart_msr_ier uart_msr_ier_inst (
    .CORE_CLK_I(clk),
    .RST_I(rst),
    .APB_REQ_I(req),
    .PRDATA_O(prdata),
    .PREADY_O(pready),
    .PSLVERR_O(pslverr),
    .PINS_I(pins),
    .EVT_I(evt),
    .RTS_N_O(rts_n),
    .DTR_N_O(dtr_n),
    .SLEEP_REQ_O(sleep_req),
    .IRQ_N_O(irq_n)
  );

  modem_side_model modem_side_model_inst (
    .clk_i(clk),
    .rst_i(rst),
    .gpio_cmd_i(gpio_cmd),
    .cts_cmd_i(cts_cmd),
    .rts_n_dev_i(rts_n),
    .pins_o(pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic chk1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // one apb transfer; starts one edge later so psel never toggles twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= {24'h0, d};
    @(posedge clk);
    req.penable <= 1'b1;
    // wait for the slave; only the bench timeout ends a hung access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rdata & {24'h0, m}, {24'h0, e});
  endtask : rd

  task automatic results;
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst <= 1'b1;
    req <= '0;
    evt <= '0;
    gpio_cmd <= 8'hff;
    cts_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // reset state
    rd(`OFF_IE_MASK, 8'hff, 8'h00);
    rd(`OFF_MODEM_STAT, 8'hff, 8'h00);
    rd(`OFF_IDENT, 8'hff, 8'h01);
    chk1(irq_n, 1'b1);
    // scratch stores, unmapped write leaves it alone
    wr(`OFF_SCRATCH, 8'ha5);
    rd(`OFF_SCRATCH, 8'hff, 8'ha5);
    wr(`OFF_SCRATCH, 8'h5a);
    wr(8'h00, 8'hff);
    chk1(rerr, 1'b1);
    rd(`OFF_SCRATCH, 8'hff, 8'h5a);
    rd(`OFF_IE_MASK, 8'hff, 8'h00);
    // upper enable bits locked until feature write enable
    wr(`OFF_IE_MASK, 8'hff);
    rd(`OFF_IE_MASK, 8'hff, 8'h0f);
    wr(`OFF_ENH_FEAT, 8'h10);
    wr(`OFF_IE_MASK, 8'hf0);
    rd(`OFF_IE_MASK, 8'hff, 8'hf0);
    chk1(sleep_req, 1'b1);
    wr(`OFF_IE_MASK, 8'h00);
    tick(1);
    chk1(sleep_req, 1'b0);
    // modem status levels and change flags
    wr(`OFF_PIN_CFG, 8'h02);
    rd(`OFF_MODEM_STAT, 8'hff, 8'h00);
    rd(`OFF_PIN_LEVEL, 8'hd0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      gpio_cmd <= lv_tab[i][7:0];
      cts_cmd <= lv_tab[i][8];
      tick(4);
      rd(`OFF_MODEM_STAT, 8'hff, ex1[i]);
      rd(`OFF_MODEM_STAT, 8'hff, ex2[i]);
    end
    // modem interrupt follows flags and enable
    wr(`OFF_IE_MASK, 8'h08);
    cts_cmd <= 1'b1;
    tick(5);
    chk1(irq_n, 1'b0);
    rd(`OFF_IDENT, 8'hff, 8'h00);
    rd(`OFF_MODEM_STAT, 8'hff, 8'h01);
    tick(3);
    chk1(irq_n, 1'b1);
    wr(`OFF_IE_MASK, 8'h00);
    cts_cmd <= 1'b0;
    tick(5);
    chk1(irq_n, 1'b1);
    rd(`OFF_MODEM_STAT, 8'hff, 8'h11);
    // level sources, masked then enabled
    for (int i = 0; i < 3; i++) begin
      evt <= uart_evt_t'(ev_tab[i]);
      tick(5);
      chk1(irq_n, 1'b1);
      wr(`OFF_IE_MASK, msk_tab[i]);
      tick(4);
      chk1(irq_n, 1'b0);
      rd(`OFF_IDENT, 8'hff, id_tab[i]);
      evt <= '0;
      wr(`OFF_IE_MASK, 8'h00);
    end
    // transmit request, then re-enabling raises nothing
    wr(`OFF_IE_MASK, 8'h02);
    evt <= uart_evt_t'(4'h2);
    tick(5);
    chk1(irq_n, 1'b0);
    rd(`OFF_IDENT, 8'hff, 8'h02);
    tick(3);
    chk1(irq_n, 1'b1);
    wr(`OFF_IE_MASK, 8'h00);
    wr(`OFF_IE_MASK, 8'h02);
    tick(4);
    chk1(irq_n, 1'b1);
    rd(`OFF_IDENT, 8'hff, 8'h01);
    evt <= '0;
    // flow change on cts rise; stale events cleared first
    rd(`OFF_FLOW_EVT, 8'hff, 8'h01);
    wr(`OFF_IE_MASK, 8'h80);
    cts_cmd <= 1'b1;
    tick(5);
    chk1(irq_n, 1'b0);
    rd(`OFF_IDENT, 8'hff, 8'h20);
    rd(`OFF_FLOW_EVT, 8'hff, 8'h01);
    tick(3);
    chk1(irq_n, 1'b1);
    rd(`OFF_MODEM_STAT, 8'hff, 8'h01);
    // flow change on rts rise
    wr(`OFF_IE_MASK, 8'h40);
    wr(`OFF_MODEM_CTRL, 8'h02);
    tick(1);
    chk1(rts_n, 1'b0);
    wr(`OFF_MODEM_CTRL, 8'h00);
    tick(5);
    chk1(irq_n, 1'b0);
    rd(`OFF_FLOW_EVT, 8'hff, 8'h02);
    wr(`OFF_IE_MASK, 8'h00);
    // loopback feeds control bits into status
    wr(`OFF_MODEM_CTRL, 8'h13);
    tick(1);
    chk1(dtr_n, 1'b0);
    rd(`OFF_MODEM_STAT, 8'h30, 8'h30);
    wr(`OFF_MODEM_CTRL, 8'h00);
    results();
  end
endmodule : uart_msr_ier_tb
